// ===== hdl/ldopc_map.svh
// Purpose: register offsets, field positions and reset values for the regulator pair control registers
// Assumes: 8-bit register port addressed by the serial interface slave outside this block
// Notes:   definitions only
`ifndef LDOPC_MAP_SVH
`define LDOPC_MAP_SVH
`define LDOPC_ADDR_A_CTRL    8'h40
`define LDOPC_ADDR_B_CTRL    8'h41
`define LDOPC_ADDR_STATUS    8'h43
`define LDOPC_VCODE_HI       4
`define LDOPC_VCODE_LO       0
`define LDOPC_ON_BIT         5
`define LDOPC_RO_BIT         6
`define LDOPC_DRAIN_BIT      7
`define LDOPC_OK_BIT         0
`define LDOPC_UNMASK_BIT     1
`define LDOPC_RST_VCODE      5'h00
`define LDOPC_RST_ON         1'b0
`define LDOPC_RST_DRAIN      1'b0
`define LDOPC_RST_UNMASK     1'b0
`define LDOPC_RST_RDATA      8'h00
`endif

// ===== hdl/ldopc_pkg.sv
// Purpose: types shared by the regulator pair control files
// Assumes: nothing
// Notes:   constants live in ldopc_map.svh
package ldopc_pkg;
  typedef logic [4:0] ldopc_vcode_t;  // 5-bit voltage code
  typedef logic [7:0] ldopc_byte_t;   // register data byte
  typedef logic [9:0] ldopc_mv_t;     // target in units of 10 mV
  typedef enum logic [1:0] {LDOPC_RANGE_LOW, LDOPC_RANGE_MIDLO, LDOPC_RANGE_MIDHI, LDOPC_RANGE_HIGH} ldopc_range_t;
endpackage

// ===== hdl/ldopc_regs.sv
// Purpose: control and status registers for the two low-noise regulators
// Assumes: a serial-interface slave outside presents one-cycle write strobes and a read address
// Notes:   read data registered, one cycle after the read address
//
// How it works
// - 5-bit voltage codes per regulator, readable, writable
// - code decoded by range and step lookup
// - bit 5 enables its own regulator
// - push-button low may also turn regulators on
// - bit 7 drains output while regulator off
// - read-only bits ignore writes
// - status bit 0 shows synchronised power-OK
// - status bit 1 is writable fault unmask
`timescale 1ns/1ps
`include "ldopc_map.svh"
module ldopc_regs (
  input  wire logic                core_clk,            // system clock
  input  wire logic                rst_b,               // async reset, active low
  input  wire logic                wr_stb,              // one-cycle write strobe
  input  wire ldopc_pkg::ldopc_byte_t reg_addr,         // register address
  input  wire ldopc_pkg::ldopc_byte_t wr_data,          // write data
  output      ldopc_pkg::ldopc_byte_t rd_data_q,        // registered read data
  input  wire ldopc_pkg::ldopc_byte_t ro_bits_a,        // part-specific read-only bits, first control
  input  wire ldopc_pkg::ldopc_byte_t ro_bits_b,        // part-specific read-only bits, second control
  input  wire ldopc_pkg::ldopc_byte_t ro_bits_s,        // part-specific read-only bits, status
  input  wire logic                push_button_input_n, // push-button pin, active low
  input  wire logic                pb_seq_a_en,         // sequence lets push-button start first
  input  wire logic                pb_seq_b_en,         // sequence lets push-button start second
  input  wire logic                power_ok_raw,        // analog comparator of first regulator
  output      logic                first_ldo_turn_on_q,  // enable to first regulator
  output      logic                second_ldo_turn_on_q, // enable to second regulator
  output      logic                first_ldo_drain_q,    // discharge switch, first
  output      logic                second_ldo_drain_q,   // discharge switch, second
  output      ldopc_pkg::ldopc_vcode_t first_ldo_voltage_code,  // voltage select, first
  output      ldopc_pkg::ldopc_vcode_t second_ldo_voltage_code, // voltage select, second
  output      ldopc_pkg::ldopc_mv_t    first_ldo_target_q,      // decoded target, first
  output      ldopc_pkg::ldopc_mv_t    second_ldo_target_q,     // decoded target, second
  output      logic                first_ldo_fault_q     // unmasked output fault
);
  import ldopc_pkg::*;
  logic [1:0] on_q;       // register enables, [0] first
  logic [1:0] drain_q;    // discharge enables
  ldopc_vcode_t vcode_q [2]; // voltage codes
  logic       unmask_q;   // fault unmask
  logic       pok_s1_q;   // synchroniser stage 1
  logic       pok_s2_q;   // synchroniser stage 2
  logic [1:0] pb_s_q;     // push-button synchroniser
  logic [1:0] pb_seq;     // sequence permits
  logic [1:0] run;        // regulator running
  ldopc_byte_t rd_d;      // read mux

  assign pb_seq = {pb_seq_b_en, pb_seq_a_en};

  // per-regulator control fields
  for (genvar i = 0; i < 2; i++) begin : g_ctl
    localparam ldopc_byte_t ADDR = (i == 0) ? `LDOPC_ADDR_A_CTRL : `LDOPC_ADDR_B_CTRL;
    // field writes; bit 6 never stored
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        vcode_q[i] <= `LDOPC_RST_VCODE;
        on_q[i]    <= `LDOPC_RST_ON;
        drain_q[i] <= `LDOPC_RST_DRAIN;
      end else if (wr_stb && reg_addr == ADDR) begin
        vcode_q[i] <= wr_data[`LDOPC_VCODE_HI:`LDOPC_VCODE_LO];
        on_q[i]    <= wr_data[`LDOPC_ON_BIT];
        drain_q[i] <= wr_data[`LDOPC_DRAIN_BIT];
      end
    end
    // run = register enable or permitted push-button start
    assign run[i] = on_q[i] | (pb_seq[i] & ~pb_s_q[1]);
  end

  // fault unmask bit; status bits 7:2 and 0 not writable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unmask_q <= `LDOPC_RST_UNMASK;
    end else if (wr_stb && reg_addr == `LDOPC_ADDR_STATUS) begin
      unmask_q <= wr_data[`LDOPC_UNMASK_BIT];
    end
  end

  // two-stage synchronisers for pin inputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pok_s1_q <= 1'b0;
      pok_s2_q <= 1'b0;
      pb_s_q   <= 2'b11;
    end else begin
      pok_s1_q <= power_ok_raw;
      pok_s2_q <= pok_s1_q;
      pb_s_q   <= {pb_s_q[0], push_button_input_n};
    end
  end

  // analog controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_ldo_turn_on_q  <= 1'b0;
      second_ldo_turn_on_q <= 1'b0;
      first_ldo_drain_q    <= 1'b0;
      second_ldo_drain_q   <= 1'b0;
      first_ldo_fault_q    <= 1'b0;
    end else begin
      first_ldo_turn_on_q  <= run[0];
      second_ldo_turn_on_q <= run[1];
      first_ldo_drain_q    <= drain_q[0] & ~run[0];
      second_ldo_drain_q   <= drain_q[1] & ~run[1];
      first_ldo_fault_q    <= unmask_q & ~pok_s2_q;
    end
  end

  assign first_ldo_voltage_code  = vcode_q[0];
  assign second_ldo_voltage_code = vcode_q[1];

  // read mux; read-only bits come from part inputs
  always_comb begin
    case (reg_addr)
      `LDOPC_ADDR_A_CTRL: rd_d = {drain_q[0], ro_bits_a[`LDOPC_RO_BIT], on_q[0], vcode_q[0]};
      `LDOPC_ADDR_B_CTRL: rd_d = {drain_q[1], ro_bits_b[`LDOPC_RO_BIT], on_q[1], vcode_q[1]};
      `LDOPC_ADDR_STATUS: rd_d = {ro_bits_s[7:2], unmask_q, pok_s2_q};
      default:            rd_d = `LDOPC_RST_RDATA;
    endcase
  end

  // registered read data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= `LDOPC_RST_RDATA;
    end else begin
      rd_data_q <= rd_d;
    end
  end

  // voltage decoders
  ldopc_vdecode u_dec_a (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .code     (vcode_q[0]),
    .target_q (first_ldo_target_q)
  );
  ldopc_vdecode u_dec_b (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .code     (vcode_q[1]),
    .target_q (second_ldo_target_q)
  );

  // checks
  AST_WR_CODE: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_A_CTRL |=> first_ldo_voltage_code == $past(wr_data[4:0]))
    else $error("first voltage code not written");
  AST_DEC: assert property (@(posedge core_clk) disable iff (!rst_b)
    vcode_q[0] == 5'h1F ##1 vcode_q[0] == 5'h1F |-> first_ldo_target_q == 10'd330)
    else $error("top code not decoded to 3.30 V");
  AST_ON: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_B_CTRL && wr_data[5] |-> ##2 second_ldo_turn_on_q)
    else $error("second regulator not enabled");
  AST_PB: assert property (@(posedge core_clk) disable iff (!rst_b)
    pb_seq_a_en && !pb_s_q[1] |=> first_ldo_turn_on_q)
    else $error("push-button did not start first regulator");
  AST_DRAIN: assert property (@(posedge core_clk) disable iff (!rst_b)
    first_ldo_drain_q |-> !first_ldo_turn_on_q)
    else $error("drain while running");
  AST_RO: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_STATUS |=> rd_data_q[7:2] == $past(ro_bits_s[7:2]))
    else $error("status read-only bit disturbed");
  AST_OK: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_addr == `LDOPC_ADDR_STATUS |=> rd_data_q[0] == $past(pok_s2_q))
    else $error("status power-OK mismatch");
  AST_SYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
    pok_s2_q == $past(power_ok_raw, 2) || !$past(rst_b, 2))
    else $error("power-OK not two stages");
  AST_FAULT: assert property (@(posedge core_clk) disable iff (!rst_b)
    first_ldo_fault_q == ($past(unmask_q) && !$past(pok_s2_q)))
    else $error("fault output wrong");
  // second code takes the written low five bits
  AST_WR_CODE_B: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_B_CTRL |=> second_ldo_voltage_code == $past(wr_data[4:0]))
    else $error("second voltage code not written");
  // writing the first control leaves the second code alone
  AST_CODE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_A_CTRL |=> $stable(second_ldo_voltage_code))
    else $error("second voltage code disturbed");
  // lowest code gives the lowest target
  AST_DEC_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    vcode_q[1] == 5'h00 ##1 vcode_q[1] == 5'h00 |-> second_ldo_target_q == 10'h05A)
    else $error("code zero not decoded to 0.90 V");
  // first step of the second range
  AST_DEC_MID: assert property (@(posedge core_clk) disable iff (!rst_b)
    vcode_q[0] == 5'h08 ##1 vcode_q[0] == 5'h08 |-> first_ldo_target_q == 10'h091)
    else $error("code eight not decoded to 1.45 V");
  // enable bit clear and button idle keeps the regulator off
  AST_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
    !on_q[0] && pb_s_q[1] |=> !first_ldo_turn_on_q)
    else $error("first regulator on without enable");
  // enable bit set always runs the regulator
  AST_ON_A: assert property (@(posedge core_clk) disable iff (!rst_b)
    on_q[0] |=> first_ldo_turn_on_q)
    else $error("first regulator not enabled");
  // permitted button press starts the second regulator
  AST_PB_B: assert property (@(posedge core_clk) disable iff (!rst_b)
    pb_seq_b_en && !pb_s_q[1] |=> second_ldo_turn_on_q)
    else $error("push-button did not start second regulator");
  // drain bit set and regulator off gives discharge
  AST_DRAIN_ON: assert property (@(posedge core_clk) disable iff (!rst_b)
    drain_q[0] && !on_q[0] && pb_s_q[1] |=> first_ldo_drain_q)
    else $error("no discharge while first regulator off");
  // second regulator never drained while running
  AST_DRAIN_B: assert property (@(posedge core_clk) disable iff (!rst_b)
    second_ldo_drain_q |-> !second_ldo_turn_on_q)
    else $error("second drain while running");
  // read-only control bit reads the part value
  AST_RO_CTRL: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_addr == `LDOPC_ADDR_A_CTRL |=> rd_data_q[`LDOPC_RO_BIT] == $past(ro_bits_a[`LDOPC_RO_BIT]))
    else $error("control read-only bit wrong");
  // fault unmask takes the written bit
  AST_UNMASK: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_stb && reg_addr == `LDOPC_ADDR_STATUS |=> unmask_q == $past(wr_data[`LDOPC_UNMASK_BIT]))
    else $error("fault unmask not written");
  // unmapped addresses read zero
  AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_addr != `LDOPC_ADDR_A_CTRL && reg_addr != `LDOPC_ADDR_B_CTRL && reg_addr != `LDOPC_ADDR_STATUS
    |=> rd_data_q == `LDOPC_RST_RDATA)
    else $error("unmapped read not zero");
endmodule // ldopc_regs

// ===== hdl/ldopc_vdecode.sv
// Purpose: registered voltage-code lookup, code to target in 10 mV units
// Assumes: code stable from control register
// Notes:   upper two bits pick a range, lower three a step
`timescale 1ns/1ps
module ldopc_vdecode (
  input  wire logic              core_clk,  // system clock
  input  wire logic              rst_b,     // async reset, active low
  input  wire ldopc_pkg::ldopc_vcode_t code,      // voltage code
  output      ldopc_pkg::ldopc_mv_t    target_q   // decoded target
);
  import ldopc_pkg::*;
  ldopc_range_t rng;   // range selected by upper bits
  ldopc_mv_t    mv_d;  // combinational lookup
  assign rng = ldopc_range_t'(code[4:3]);
  // lookup table of the printed voltages
  always_comb begin
    mv_d = 10'h000;
    case (rng)
      LDOPC_RANGE_LOW: begin
        case (code[2:0])
          3'h0: mv_d = 10'd90;  3'h1: mv_d = 10'd100; 3'h2: mv_d = 10'd110; 3'h3: mv_d = 10'd120;
          3'h4: mv_d = 10'd125; 3'h5: mv_d = 10'd130; 3'h6: mv_d = 10'd135; default: mv_d = 10'd140;
        endcase
      end
      LDOPC_RANGE_MIDLO: begin
        case (code[2:0])
          3'h0: mv_d = 10'd145; 3'h1: mv_d = 10'd150; 3'h2: mv_d = 10'd155; 3'h3: mv_d = 10'd160;
          3'h4: mv_d = 10'd170; 3'h5: mv_d = 10'd175; 3'h6: mv_d = 10'd180; default: mv_d = 10'd185;
        endcase
      end
      LDOPC_RANGE_MIDHI: begin
        case (code[2:0])
          3'h0: mv_d = 10'd190; 3'h1: mv_d = 10'd200; 3'h2: mv_d = 10'd210; 3'h3: mv_d = 10'd220;
          3'h4: mv_d = 10'd240; 3'h5: mv_d = 10'd250; 3'h6: mv_d = 10'd260; default: mv_d = 10'd270;
        endcase
      end
      default: begin
        case (code[2:0])
          3'h0: mv_d = 10'd275; 3'h1: mv_d = 10'd280; 3'h2: mv_d = 10'd285; 3'h3: mv_d = 10'd290;
          3'h4: mv_d = 10'd300; 3'h5: mv_d = 10'd310; 3'h6: mv_d = 10'd320; default: mv_d = 10'd330;
        endcase
      end
    endcase
  end
  // output register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= 10'h000;
    end else begin
      target_q <= mv_d;
    end
  end
endmodule // ldopc_vdecode

// ===== test/ldo_pair_control_regs_tb.sv
// Purpose: self-checking bench for the regulator pair registers
// Assumes: controls and targets settle two edges after a write
// Notes:   inputs driven at the falling edge
`timescale 1ns/1ps
`include "ldopc_map.svh"
module ldo_pair_control_regs_tb;
  import ldopc_pkg::*;
  logic        core_clk = 1'b0;  // clock
  logic        rst_b    = 1'b0;  // reset
  logic        pb_n     = 1'b1;  // push-button pin
  logic        seq_a    = 1'b0;  // button permits
  logic        seq_b    = 1'b0;
  logic        pok      = 1'b1;  // comparator
  logic        wr_stb, on_a, on_b, dr_a, dr_b, fault;
  ldopc_byte_t reg_addr, wr_data, rd_data_q, rd;
  ldopc_vcode_t code_a, code_b;
  ldopc_mv_t   tgt_a, tgt_b;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // expected targets in 10 mV units
  ldopc_mv_t   mv [32] = '{90, 100, 110, 120, 125, 130, 135, 140, 145, 150, 155, 160, 170, 175, 180, 185,
                           190, 200, 210, 220, 240, 250, 260, 270, 275, 280, 285, 290, 300, 310, 320, 330};
  always #10 core_clk = ~core_clk;
  ldopc_host i_host (.core_clk(core_clk), .wr_stb(wr_stb), .reg_addr(reg_addr), .wr_data(wr_data),
                     .rd_data_q(rd_data_q));
  ldopc_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .wr_stb(wr_stb), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_data_q(rd_data_q), .ro_bits_a(8'h40), .ro_bits_b(8'h00), .ro_bits_s(8'hA8),
    .push_button_input_n(pb_n), .pb_seq_a_en(seq_a), .pb_seq_b_en(seq_b), .power_ok_raw(pok),
    .first_ldo_turn_on_q(on_a), .second_ldo_turn_on_q(on_b), .first_ldo_drain_q(dr_a),
    .second_ldo_drain_q(dr_b), .first_ldo_voltage_code(code_a), .second_ldo_voltage_code(code_b),
    .first_ldo_target_q(tgt_a), .second_ldo_target_q(tgt_b), .first_ldo_fault_q(fault));
  // one compare for every value kind
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // single closing point
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // state straight after reset
  task automatic t_reset();
    @(negedge core_clk);
    chk("tgt_a", 90, tgt_a);
    i_host.rd(`LDOPC_ADDR_A_CTRL, rd);
    chk("rd_a", 8'h40, rd);
    chk("on_a", 0, on_a);
  endtask
  // every code on the first regulator, second untouched
  task automatic t_codes();
    logic [4:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      i_host.wr(`LDOPC_ADDR_A_CTRL, {c[1], 1'b0, c[0], c});
      repeat (2) @(negedge core_clk);
      chk("code_a", c, code_a);
      chk("tgt_a", mv[i], tgt_a);
      chk("on_a", c[0], on_a);
      chk("dr_a", c[1] & ~c[0], dr_a);
      chk("code_b", 0, code_b);
      i_host.rd(`LDOPC_ADDR_A_CTRL, rd);
      chk("rd_a", {c[1], 1'b1, c[0], c}, rd);
    end
  endtask
  // second regulator off with drain, then running
  task automatic t_second();
    for (int j = 0; j < 2; j++) begin
      i_host.wr(`LDOPC_ADDR_B_CTRL, j ? 8'hFF : 8'hDE);
      repeat (2) @(negedge core_clk);
      chk("on_b", j, on_b);
      chk("dr_b", 1 - j, dr_b);
      chk("tgt_b", mv[30 + j], tgt_b);
      chk("code_a", 5'h1F, code_a);
      i_host.rd(`LDOPC_ADDR_B_CTRL, rd);
      chk("rd_b", j ? 8'hBF : 8'h9E, rd);
    end
  endtask
  // status bits, synchroniser delay, fault masking
  task automatic t_status();
    i_host.wr(`LDOPC_ADDR_STATUS, 8'hFE);
    i_host.rd(`LDOPC_ADDR_STATUS, rd);
    chk("rd_s", 8'hAB, rd);
    pok = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("fault", 0, fault);
    @(negedge core_clk);
    chk("fault", 1, fault);
    chk("ok", 0, rd_data_q[0]);
    i_host.wr(`LDOPC_ADDR_STATUS, 8'h01);
    repeat (3) @(negedge core_clk);
    chk("fault", 0, fault);
    pok = 1'b1;
  endtask
  // push-button start only where the sequence permits
  task automatic t_button();
    i_host.wr(`LDOPC_ADDR_A_CTRL, 8'h80);
    i_host.wr(`LDOPC_ADDR_B_CTRL, 8'h80);
    pb_n  = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("on_a", 0, on_a);
    chk("dr_a", 1, dr_a);
    seq_a = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("on_a", 1, on_a);
    chk("dr_a", 0, dr_a);
    chk("on_b", 0, on_b);
    seq_b = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("on_b", 1, on_b);
    chk("dr_b", 0, dr_b);
    pb_n  = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("on_a", 0, on_a);
    chk("dr_a", 1, dr_a);
    seq_a = 1'b0;
    seq_b = 1'b0;
    i_host.wr(`LDOPC_ADDR_B_CTRL, 8'hFF);
    repeat (2) @(negedge core_clk);
    chk("on_b", 1, on_b);
  endtask
  // unmapped place reads zero and ignores writes
  task automatic t_unmapped();
    i_host.wr(8'h42, 8'hFF);
    i_host.rd(8'h42, rd);
    chk("rd_42", 0, rd);
    i_host.rd(`LDOPC_ADDR_B_CTRL, rd);
    chk("rd_b", 8'hBF, rd);
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    t_codes();
    t_second();
    t_status();
    t_button();
    t_unmapped();
    give_verdict();
  end
endmodule // ldo_pair_control_regs_tb

// ===== test/ldopc_host.sv
// Purpose: host model that writes and reads the registers
// Assumes: device inputs change at the falling edge
// Notes:   write data is inverted once the strobe drops
`timescale 1ns/1ps
module ldopc_host (
  input  wire logic                   core_clk,  // system clock
  output      logic                   wr_stb,    // write strobe
  output      ldopc_pkg::ldopc_byte_t reg_addr,  // register address
  output      ldopc_pkg::ldopc_byte_t wr_data,   // write data
  input  wire ldopc_pkg::ldopc_byte_t rd_data_q  // read data
);
  import ldopc_pkg::*;
  // idle bus at time zero
  initial begin
    wr_stb   = 1'b0;
    reg_addr = 8'h00;
    wr_data  = 8'h00;
  end
  // one write, strobe high for exactly one rising edge
  task automatic wr(input ldopc_byte_t a, input ldopc_byte_t d);
    @(negedge core_clk);
    wr_stb   = 1'b1;
    reg_addr = a;
    wr_data  = d;
    @(negedge core_clk);
    wr_stb  = 1'b0;
    wr_data = ~d;     // stale data must not look valid
  endtask
  // read, data taken after the next rising edge
  task automatic rd(input ldopc_byte_t a, output ldopc_byte_t d);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    d = rd_data_q;
  endtask
endmodule // ldopc_host
